// ### csr_core.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
// How it works
// RULE_01 - bank selector holds only bit 0; bits 7 to 1 read zero
// RULE_02 - any reset returns bank 0, except watchdog reset while powered down
// RULE_03 - direct data access always goes to bank 0; indirect uses selector
// RULE_04 - every ALU result lands in the working register
// RULE_05 - no register-to-register move; data passes through working register
// RULE_06 - program-count-low write replaces low pc byte, jump within page
// RULE_07 - a program-count-low jump inserts one dummy instruction cycle
// RULE_08 - software loads table pointers before a table read; may step them
// RULE_09 - table read puts high byte in upper register, low to destination
// RULE_10 - arithmetic flags writable; writes never touch expiry or sleep flags
// RULE_11 - expiry flag bit 5 cleared by power-up, clear, sleep; set on expiry
// RULE_12 - sleep flag bit 4 cleared by power-up or clear; set by sleep
// RULE_13 - carry bit 0 from add carry, subtract no-borrow, and rotates
// RULE_14 - aux carry bit 1 from low-nibble carry or no nibble borrow
// RULE_15 - zero bit 2 set when arithmetic or logical result is zero
// RULE_16 - overflow bit 3 when carry into msb differs from carry out
// RULE_17 - status is never saved on stack at call or interrupt entry
// RULE_18 - status bits 7 and 6 read zero; system flags reset to zero
module csr_core #(
  parameter int PC_W = 12
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire csr_pkg::csr_alu_req_t alu_req,
  input wire logic mem_indirect,
  input wire logic pc_advance,
  input wire logic wdt_expire,
  input wire logic wdt_reset,
  output logic [7:0] working_register,
  output logic [7:0] status_out,
  output logic data_bank_select,
  output logic [PC_W-1:0] pc_out,
  output logic [15:0] table_addr,
  output logic dummy_cycle,
  output csr_pkg::csr_mem_wr_t mem_wr,
  output logic irq
);
  import csr_pkg::*;

  logic bank_select_reg;
  logic [7:0] work_reg;
  logic [7:0] status_reg;
  logic [7:0] tbl_lo_reg;
  logic [7:0] tbl_hi_reg;
  logic [7:0] tbl_up_reg;
  logic [PC_W-1:0] pc_reg;
  logic dummy_reg;
  logic eff_bank_reg;
  csr_mem_wr_t mem_wr_reg;
  logic [7:0] rdata_reg;
  logic [CSR_IRQ_W-1:0] irq_stat_reg;
  logic [CSR_IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;

  logic wr_bank, wr_work, wr_pcl, wr_tlo, wr_thi, wr_status, wr_istat, wr_imask;
  logic [7:0] alu_next;
  logic [3:0] flag_next;
  logic [3:0] flag_mask;
  logic alu_writes;
  logic [CSR_IRQ_W-1:0] irq_ev;

  // write decode
  always_comb begin
    wr_bank = 1'b0;
    wr_work = 1'b0;
    wr_pcl = 1'b0;
    wr_tlo = 1'b0;
    wr_thi = 1'b0;
    wr_status = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    if (reg_wr && reg_addr == CSR_OFF_BANK) begin
      wr_bank = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_WORK) begin
      wr_work = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_PCL) begin
      wr_pcl = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_TBL_LO) begin
      wr_tlo = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_TBL_HI) begin
      wr_thi = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_IRQ_STAT) begin
      wr_istat = 1'b1;
    end else if (reg_wr && reg_addr == CSR_OFF_IRQ_MASK) begin
      wr_imask = 1'b1;
    end
  end

  // alu: result and arithmetic flags
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b;
    logic cin;
    sum = 9'h000;
    nib = 5'h00;
    b = 8'h00;
    cin = 1'b0;
    alu_next = work_reg;
    flag_next = status_reg[3:0];
    flag_mask = 4'h0;
    alu_writes = 1'b0;
    case (alu_req.op)
      CSR_OP_ADD, CSR_OP_SUB: begin
        b = (alu_req.op == CSR_OP_SUB) ? ~alu_req.operand : alu_req.operand;
        cin = (alu_req.op == CSR_OP_SUB);
        sum = {1'b0, work_reg} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, work_reg[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        alu_next = sum[7:0];
        flag_next[CSR_ST_C] = sum[8]; // RULE_13
        flag_next[CSR_ST_AC] = nib[CSR_NIB]; // RULE_14
        flag_next[CSR_ST_Z] = (sum[7:0] == CSR_ZERO8); // RULE_15
        flag_next[CSR_ST_OV] = sum[8] ^ (work_reg[7] ^ b[7] ^ sum[7]); // RULE_16
        flag_mask = 4'hF;
        alu_writes = 1'b1;
      end
      CSR_OP_AND, CSR_OP_OR, CSR_OP_XOR: begin
        if (alu_req.op == CSR_OP_AND) begin
          alu_next = work_reg & alu_req.operand;
        end else if (alu_req.op == CSR_OP_OR) begin
          alu_next = work_reg | alu_req.operand;
        end else begin
          alu_next = work_reg ^ alu_req.operand;
        end
        flag_next[CSR_ST_Z] = (alu_next == CSR_ZERO8); // RULE_15
        flag_mask[CSR_ST_Z] = 1'b1;
        alu_writes = 1'b1;
      end
      CSR_OP_RLC: begin
        alu_next = {alu_req.operand[6:0], status_reg[CSR_ST_C]};
        flag_next[CSR_ST_C] = alu_req.operand[7]; // RULE_13
        flag_mask[CSR_ST_C] = 1'b1;
        alu_writes = 1'b1;
      end
      CSR_OP_RRC: begin
        alu_next = {status_reg[CSR_ST_C], alu_req.operand[7:1]};
        flag_next[CSR_ST_C] = alu_req.operand[0]; // RULE_13
        flag_mask[CSR_ST_C] = 1'b1;
        alu_writes = 1'b1;
      end
      CSR_OP_LOAD: begin
        alu_next = alu_req.operand; // RULE_05
        alu_writes = 1'b1;
      end
      CSR_OP_TABRD: begin
        alu_next = alu_req.prog_word[7:0]; // RULE_09
        alu_writes = 1'b1;
      end
      default: begin
        alu_next = work_reg;
      end
    endcase
  end

  // working register, alu wins over bus write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      work_reg <= CSR_ZERO8;
    end else if (alu_writes) begin
      work_reg <= alu_next; // RULE_04
    end else if (wr_work) begin
      work_reg <= reg_wdata;
    end
  end

  // memory write only ever from the working register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_wr_reg <= '0;
    end else begin
      mem_wr_reg.valid <= (alu_req.op == CSR_OP_STORE); // RULE_05
      mem_wr_reg.data <= work_reg;
    end
  end

  // status register; only copy of the flags, nothing pushes it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= CSR_STATUS_RST; // RULE_18
    end else begin
      if (wr_status) begin
        status_reg[3:0] <= reg_wdata[3:0] & CSR_ST_ARITH_MASK[3:0]; // RULE_10
      end
      for (int i = 0; i < 4; i++) begin
        if (flag_mask[i]) begin
          status_reg[i] <= flag_next[i]; // RULE_17
        end
      end
      if (wdt_expire) begin
        status_reg[CSR_ST_TO] <= 1'b1; // RULE_11
      end else if (alu_req.op == CSR_OP_CLRWDT || alu_req.op == CSR_OP_HALT) begin
        status_reg[CSR_ST_TO] <= 1'b0; // RULE_11
      end
      if (alu_req.op == CSR_OP_HALT) begin
        status_reg[CSR_ST_PDF] <= 1'b1; // RULE_12
      end else if (alu_req.op == CSR_OP_CLRWDT) begin
        status_reg[CSR_ST_PDF] <= 1'b0; // RULE_12
      end
      status_reg[7:6] <= 2'b00; // RULE_18
    end
  end

  // bank selector
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_select_reg <= CSR_BANK_RST[0]; // RULE_02
    end else if (wdt_reset) begin
      if (!status_reg[CSR_ST_PDF]) begin
        bank_select_reg <= CSR_BANK_RST[0]; // RULE_02
      end
    end else if (wr_bank) begin
      bank_select_reg <= reg_wdata[0]; // RULE_01
    end
  end

  // effective bank for the current access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eff_bank_reg <= 1'b0;
    end else begin
      eff_bank_reg <= mem_indirect & bank_select_reg; // RULE_03
    end
  end

  // table pointers and upper byte latch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbl_lo_reg <= CSR_ZERO8;
      tbl_hi_reg <= CSR_ZERO8;
      tbl_up_reg <= CSR_ZERO8;
    end else begin
      if (wr_tlo) begin
        tbl_lo_reg <= reg_wdata;
      end
      if (wr_thi) begin
        tbl_hi_reg <= reg_wdata;
      end
      if (alu_req.op == CSR_OP_TABRD) begin
        tbl_up_reg <= alu_req.prog_word[15:8]; // RULE_09
      end
    end
  end

  // program counter and dummy cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= '0;
      dummy_reg <= 1'b0;
    end else begin
      dummy_reg <= wr_pcl; // RULE_07
      if (wr_pcl) begin
        pc_reg <= {pc_reg[PC_W-1:8], reg_wdata}; // RULE_06
      end else if (pc_advance && !dummy_reg) begin
        pc_reg <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // interrupt status, mask and output
  assign irq_ev[CSR_EV_WDT] = wdt_expire;
  assign irq_ev[CSR_EV_HALT] = (alu_req.op == CSR_OP_HALT);
  assign irq_ev[CSR_EV_JUMP] = wr_pcl;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_istat) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[CSR_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      if (wr_imask) begin
        irq_mask_reg <= reg_wdata[CSR_IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read port, data valid one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= CSR_ZERO8;
    end else if (!reg_rd) begin
      rdata_reg <= CSR_ZERO8;
    end else if (reg_addr == CSR_OFF_BANK) begin
      rdata_reg <= {7'h00, bank_select_reg}; // RULE_01
    end else if (reg_addr == CSR_OFF_WORK) begin
      rdata_reg <= work_reg;
    end else if (reg_addr == CSR_OFF_PCL) begin
      rdata_reg <= pc_reg[7:0];
    end else if (reg_addr == CSR_OFF_TBL_LO) begin
      rdata_reg <= tbl_lo_reg;
    end else if (reg_addr == CSR_OFF_TBL_UP) begin
      rdata_reg <= tbl_up_reg;
    end else if (reg_addr == CSR_OFF_TBL_HI) begin
      rdata_reg <= tbl_hi_reg;
    end else if (reg_addr == CSR_OFF_STATUS) begin
      rdata_reg <= {2'b00, status_reg[5:0]}; // RULE_18
    end else if (reg_addr == CSR_OFF_IRQ_STAT) begin
      rdata_reg <= {{(8-CSR_IRQ_W){1'b0}}, irq_stat_reg};
    end else if (reg_addr == CSR_OFF_IRQ_MASK) begin
      rdata_reg <= {{(8-CSR_IRQ_W){1'b0}}, irq_mask_reg};
    end else begin
      rdata_reg <= CSR_ZERO8;
    end
  end

  assign reg_rdata = rdata_reg;
  assign working_register = work_reg;
  assign status_out = status_reg;
  assign data_bank_select = eff_bank_reg;
  assign pc_out = pc_reg;
  assign table_addr = {tbl_hi_reg, tbl_lo_reg};
  assign dummy_cycle = dummy_reg;
  assign mem_wr = mem_wr_reg;
  assign irq = irq_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_BANK_READ: assert property (reg_rd && reg_addr == CSR_OFF_BANK |=> reg_rdata[7:1] == 7'h00) // RULE_01
    else $error("bank selector upper bits not zero");
  AST_WDT_RST_BANK: assert property (wdt_reset && !status_reg[CSR_ST_PDF] |=> !bank_select_reg) // RULE_02
    else $error("bank not cleared by watchdog reset");
  AST_WDT_RST_KEEP: assert property (wdt_reset && status_reg[CSR_ST_PDF] |=> $stable(bank_select_reg)) // RULE_02
    else $error("bank changed by watchdog reset in power down");
  AST_DIRECT_BANK0: assert property (!mem_indirect |=> !data_bank_select) // RULE_03
    else $error("direct access left bank 0");
  AST_ADD_RESULT: assert property (alu_req.op == CSR_OP_ADD
      |=> working_register == 8'($past(work_reg) + $past(alu_req.operand))) // RULE_04
    else $error("add result not in working register");
  AST_PCL_JUMP: assert property (wr_pcl |=> pc_out[7:0] == $past(reg_wdata)
      && pc_out[PC_W-1:8] == $past(pc_reg[PC_W-1:8])) // RULE_06
    else $error("pcl jump wrong");
  AST_DUMMY: assert property (wr_pcl ##1 !wr_pcl |-> dummy_cycle ##1 !dummy_cycle) // RULE_07
    else $error("dummy cycle missing or long");
  AST_TABRD: assert property (alu_req.op == CSR_OP_TABRD
      |=> tbl_up_reg == $past(alu_req.prog_word[15:8]) && working_register == $past(alu_req.prog_word[7:0])) // RULE_09
    else $error("table read bytes misplaced");
  AST_STATUS_RO: assert property (wr_status && alu_req.op == CSR_OP_NOP && !wdt_expire
      |=> $stable(status_reg[5:4])) // RULE_10
    else $error("status write touched system flags");
  AST_HALT: assert property (alu_req.op == CSR_OP_HALT && !wdt_expire
      |=> status_reg[CSR_ST_PDF] && !status_reg[CSR_ST_TO]) // RULE_12
    else $error("halt flags wrong");
  AST_WDT_SET: assert property (wdt_expire |=> status_reg[CSR_ST_TO]) // RULE_11
    else $error("expiry flag not set");
  AST_SUB_CARRY: assert property (alu_req.op == CSR_OP_SUB
      |=> status_reg[CSR_ST_C] == ($past(work_reg) >= $past(alu_req.operand))) // RULE_13
    else $error("subtract carry wrong");
  AST_ZERO: assert property (alu_req.op == CSR_OP_XOR && alu_req.operand == work_reg
      |=> status_reg[CSR_ST_Z]) // RULE_15
    else $error("zero flag not set");

  COV_JUMP: cover property (wr_pcl ##1 dummy_cycle ##1 pc_advance);
  COV_HALT_WDT: cover property (alu_req.op == CSR_OP_HALT ##[1:20] wdt_reset);
  COV_IRQ: cover property (irq_ev[CSR_EV_WDT] ##[1:5] irq);

endmodule : csr_core

// ### csr_pkg.sv
package csr_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] CSR_OFF_BANK = 8'h04;
  localparam logic [7:0] CSR_OFF_WORK = 8'h05;
  localparam logic [7:0] CSR_OFF_PCL = 8'h06;
  localparam logic [7:0] CSR_OFF_TBL_LO = 8'h07;
  localparam logic [7:0] CSR_OFF_TBL_UP = 8'h08;
  localparam logic [7:0] CSR_OFF_TBL_HI = 8'h09;
  localparam logic [7:0] CSR_OFF_STATUS = 8'h0A;
  localparam logic [7:0] CSR_OFF_IRQ_STAT = 8'h60;
  localparam logic [7:0] CSR_OFF_IRQ_MASK = 8'h61;

  // status field positions
  localparam int CSR_ST_C = 0;
  localparam int CSR_ST_AC = 1;
  localparam int CSR_ST_Z = 2;
  localparam int CSR_ST_OV = 3;
  localparam int CSR_ST_PDF = 4;
  localparam int CSR_ST_TO = 5;
  localparam logic [7:0] CSR_ST_ARITH_MASK = 8'h0F;

  // interrupt event positions
  localparam int CSR_IRQ_W = 3;
  localparam int CSR_EV_WDT = 0;
  localparam int CSR_EV_HALT = 1;
  localparam int CSR_EV_JUMP = 2;

  localparam logic [7:0] CSR_ZERO8 = 8'h00;
  localparam logic [7:0] CSR_BANK_RST = 8'h00;
  localparam logic [7:0] CSR_STATUS_RST = 8'h00;
  localparam int CSR_NIB = 4;

  typedef enum logic [3:0] {
    CSR_OP_NOP = 4'h0,
    CSR_OP_ADD = 4'h1,
    CSR_OP_SUB = 4'h2,
    CSR_OP_AND = 4'h3,
    CSR_OP_OR = 4'h4,
    CSR_OP_XOR = 4'h5,
    CSR_OP_RLC = 4'h6,
    CSR_OP_RRC = 4'h7,
    CSR_OP_LOAD = 4'h8,
    CSR_OP_STORE = 4'h9,
    CSR_OP_TABRD = 4'hA,
    CSR_OP_CLRWDT = 4'hB,
    CSR_OP_HALT = 4'hC
  } csr_op_t;

  typedef struct packed {
    csr_op_t op;
    logic [7:0] operand;
    logic [15:0] prog_word;
  } csr_alu_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } csr_mem_wr_t;

endpackage : csr_pkg

// ### csr_dec_model.sv
`timescale 1ns/100ps
module csr_dec_model (
  input wire logic sys_clk,
  output csr_pkg::csr_alu_req_t alu_req
);
  import csr_pkg::*;
  initial alu_req = '{CSR_OP_NOP, 8'h00, 16'h0000};
  // one instruction per call, then back to no-op
  task automatic issue(input csr_op_t op, input logic [7:0] opd, input logic [15:0] pw);
    @(posedge sys_clk);
    alu_req <= '{op, opd, pw};
    @(posedge sys_clk);
    alu_req <= '{CSR_OP_NOP, 8'h00, 16'h0000};
  endtask : issue
endmodule : csr_dec_model

// ### cpu_core_special_registers_tb_top.sv
`timescale 1ns/100ps
module cpu_core_special_registers_tb_top;
  import csr_pkg::*;
  typedef struct {
    csr_op_t op;
    logic [7:0] opd;
    logic [7:0] work;
    logic [3:0] fl;
    logic [3:0] mk;
  } csr_row_t;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic mem_indirect = 1'h0;
  logic pc_advance = 1'h0;
  logic wdt_expire = 1'h0;
  logic wdt_reset = 1'h0;
  logic [7:0] reg_rdata;
  csr_alu_req_t alu_req;
  logic [7:0] working_register;
  logic [7:0] status_out;
  logic data_bank_select;
  logic [11:0] pc_out;
  logic [15:0] table_addr;
  logic dummy_cycle;
  csr_mem_wr_t mem_wr;
  logic irq;
  int miscompares = 0;
  int samples_checked = 0;
  // op, operand, working result, flags [3:0], flag mask
  csr_row_t rows [12] = '{
    '{CSR_OP_LOAD, 8'h0F, 8'h0F, 4'h0, 4'h0},
    '{CSR_OP_ADD, 8'h01, 8'h10, 4'h2, 4'hF},
    '{CSR_OP_ADD, 8'hF0, 8'h00, 4'h5, 4'hF},
    '{CSR_OP_LOAD, 8'h7F, 8'h7F, 4'h0, 4'h0},
    '{CSR_OP_ADD, 8'h01, 8'h80, 4'hA, 4'hF},
    '{CSR_OP_SUB, 8'h01, 8'h7F, 4'h9, 4'hF},
    '{CSR_OP_SUB, 8'h7F, 8'h00, 4'h7, 4'hF},
    '{CSR_OP_OR, 8'h5A, 8'h5A, 4'h3, 4'hF},
    '{CSR_OP_AND, 8'h0F, 8'h0A, 4'h3, 4'hF},
    '{CSR_OP_XOR, 8'h0A, 8'h00, 4'h7, 4'hF},
    '{CSR_OP_RLC, 8'h81, 8'h03, 4'h1, 4'h1},
    '{CSR_OP_RRC, 8'h02, 8'h81, 4'h0, 4'h1}
  };
  always #2 sys_clk = ~sys_clk;
  csr_dec_model dec (
    .sys_clk(sys_clk),
    .alu_req(alu_req)
  );
  csr_core #(.PC_W(12)) dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .alu_req(alu_req),
    .mem_indirect(mem_indirect),
    .pc_advance(pc_advance),
    .wdt_expire(wdt_expire),
    .wdt_reset(wdt_reset),
    .working_register(working_register),
    .status_out(status_out),
    .data_bank_select(data_bank_select),
    .pc_out(pc_out),
    .table_addr(table_addr),
    .dummy_cycle(dummy_cycle),
    .mem_wr(mem_wr),
    .irq(irq)
  );
  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rdchk
  task automatic run_op(input csr_op_t op, input logic [7:0] v, input logic [15:0] w);
    dec.issue(op, v, w);
    #1;
  endtask : run_op
  task automatic ev(input logic rst);
    @(posedge sys_clk);
    if (rst)
      wdt_reset <= 1'h1;
    else
      wdt_expire <= 1'h1;
    @(posedge sys_clk);
    wdt_reset <= 1'h0;
    wdt_expire <= 1'h0;
    #1;
  endtask : ev
  task automatic do_reset;
    @(posedge sys_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
  endtask : do_reset
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    rdchk(CSR_OFF_STATUS, CSR_STATUS_RST);
    rdchk(CSR_OFF_BANK, CSR_BANK_RST);
    rdchk(8'h30, 8'h00);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].opd, 16'h0000);
      chk("work", {8'h00, rows[i].work}, {8'h00, working_register});
      chk("flags", {12'h000, rows[i].fl & rows[i].mk}, {12'h000, status_out[3:0] & rows[i].mk});
    end
    // bank selector and direct versus indirect access
    wr(CSR_OFF_BANK, 8'hFF);
    rdchk(CSR_OFF_BANK, 8'h01);
    @(posedge sys_clk);
    mem_indirect <= 1'h1;
    tick(2);
    chk("bank", 16'h0001, {15'h0000, data_bank_select});
    @(posedge sys_clk);
    mem_indirect <= 1'h0;
    tick(2);
    chk("bank", 16'h0000, {15'h0000, data_bank_select});
    // status writes and system flags
    wr(CSR_OFF_STATUS, 8'hFF);
    rdchk(CSR_OFF_STATUS, 8'h0F);
    run_op(CSR_OP_HALT, 8'h00, 16'h0000);
    wr(CSR_OFF_STATUS, 8'h00);
    rdchk(CSR_OFF_STATUS, 8'h10);
    ev(1'h1);
    rdchk(CSR_OFF_BANK, 8'h01);
    ev(1'h0);
    chk("status", 16'h0030, {8'h00, status_out});
    run_op(CSR_OP_HALT, 8'h00, 16'h0000);
    chk("status", 16'h0010, {8'h00, status_out});
    ev(1'h0);
    run_op(CSR_OP_CLRWDT, 8'h00, 16'h0000);
    chk("status", 16'h0000, {8'h00, status_out});
    ev(1'h1);
    rdchk(CSR_OFF_BANK, 8'h00);
    // jumps through the low program count byte
    wr(CSR_OFF_PCL, 8'hFF);
    @(posedge sys_clk);
    pc_advance <= 1'h1;
    @(posedge sys_clk);
    pc_advance <= 1'h0;
    #1;
    chk("pc", 16'h0100, {4'h0, pc_out});
    @(posedge sys_clk);
    pc_advance <= 1'h1;
    wr(CSR_OFF_PCL, 8'h34);
    chk("dummy", 16'h0001, {15'h0000, dummy_cycle});
    chk("pc", 16'h0134, {4'h0, pc_out});
    @(posedge sys_clk);
    pc_advance <= 1'h0;
    #1;
    chk("dummy", 16'h0000, {15'h0000, dummy_cycle});
    chk("pc", 16'h0134, {4'h0, pc_out});
    rdchk(CSR_OFF_PCL, 8'h34);
    tick(1);
    chk("rdata", 16'h0000, {8'h00, reg_rdata});
    // table read
    wr(CSR_OFF_TBL_LO, 8'h12);
    wr(CSR_OFF_TBL_HI, 8'hAB);
    chk("taddr", 16'hAB12, table_addr);
    run_op(CSR_OP_TABRD, 8'h00, 16'hBEEF);
    chk("work", 16'h00EF, {8'h00, working_register});
    wr(CSR_OFF_TBL_UP, 8'h00);
    rdchk(CSR_OFF_TBL_UP, 8'hBE);
    // transfer through the working register
    wr(CSR_OFF_WORK, 8'h5C);
    rdchk(CSR_OFF_WORK, 8'h5C);
    run_op(CSR_OP_STORE, 8'h00, 16'h0000);
    chk("memwr", 16'h015C, {7'h00, mem_wr});
    // interrupt status, mask and clear
    wr(CSR_OFF_IRQ_MASK, 8'h00);
    wr(CSR_OFF_IRQ_STAT, 8'h07);
    rdchk(CSR_OFF_IRQ_STAT, 8'h00);
    ev(1'h0);
    rdchk(CSR_OFF_IRQ_STAT, 8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(CSR_OFF_IRQ_MASK, 8'h01);
    tick(1);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(CSR_OFF_IRQ_STAT, 8'h01);
    tick(1);
    chk("irq", 16'h0000, {15'h0000, irq});
    // second reset in mid-run
    wr(CSR_OFF_BANK, 8'h01);
    do_reset();
    rdchk(CSR_OFF_BANK, 8'h00);
    rdchk(CSR_OFF_STATUS, 8'h00);
    print_verdict();
  end
endmodule : cpu_core_special_registers_tb_top
